// file: hdl/dvm_buck_voltage_ramp_ctrl.sv
// Voltage code registers and ramp engines for two scalable bucks, two
// fixed-rate linear regulators and one fixed buck, reached over I2C.
// Assumes SCL, SDA and the core enable pin are asynchronous to MCLK.
`timescale 1ns/10ps
`include "dvm_ramp_consts.svh"

// Summary of operation
// - Ramps step code by code unless instant; buck_a restore jumps
// - Each scalable buck has its own slew code
// - Linear regulators ramp at fixed 7 mV/us
// - Voltage fields bits 4:0, slew bits 2:0
// - Scalable buck code: 0.725 V plus 25 mV
// - Slew 000 instant, 001-110 doubling, 111 reserved
// - Fixed register: buck_c 4:0, linear_reg_eight 7:5
// - Buck_c code: 3.000 V plus 50 mV
// - Primary and secondary codes, host writes first
// - Go bit starts ramp; selects pick target
// - Core enable falling restores buck_a default code
module dvm_buck_voltage_ramp_ctrl #(
    parameter logic [6:0]  DEV_ADDR  = 7'h2D,  // arbitrary default
    parameter int          CNT_W     = 16,
    parameter int          SLOW_STEP = `SLOW_STEP_CYCLES
) (
    input  wire logic                     MCLK,
    input  wire logic                     SYS_RST,
    input  wire logic                     SCL,
    input  wire logic                     SDA_I,
    output logic                          SDA_O,
    output logic                          SDA_OE,
    input  wire logic                     CORE_ENABLE_PIN,
    output logic                          BUCK_A_ON,
    output dvm_ramp_pkg::volt_code_t      BUCK_A_CODE,
    output dvm_ramp_pkg::volt_code_t      BUCK_B_CODE,
    output dvm_ramp_pkg::volt_code_t      BUCK_C_CODE,
    output logic [2:0]                    LREG8_CODE,
    output dvm_ramp_pkg::volt_code_t      LREG2_CODE,
    output dvm_ramp_pkg::volt_code_t      LREG4_CODE,
    output logic [12:0]                   BUCK_A_MV,
    output logic [12:0]                   BUCK_B_MV,
    output logic [12:0]                   BUCK_C_MV,
    output logic [3:0]                    RAMP_BUSY
);
    import dvm_ramp_pkg::*;

    localparam logic [CNT_W-1:0] LREG_STEP = CNT_W'(`LREG_STEP_CYCLES);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [2:0] scl_q, sda_q, pin_q;
    // Second and third stages feed edge detection; the first is never read by logic
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            pin_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], SCL};
            sda_q <= {sda_q[1:0], SDA_I};
            pin_q <= {pin_q[1:0], CORE_ENABLE_PIN};
        end
    end

    wire scl_rise = scl_q[1] & ~scl_q[2];
    wire scl_fall = ~scl_q[1] & scl_q[2];
    wire sda_bit  = sda_q[1];
    wire bus_start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    wire bus_stop  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
    wire en_evt    = ~pin_q[1] & pin_q[2];  // Enabling edge

    // ************************************************************
    // Register file
    // ************************************************************
    volt_code_t ba_v1_q, ba_v2_q, bb_v1_q, bb_v2_q, l2_tgt_q, l4_tgt_q;
    slew_code_t ba_sl_q, bb_sl_q;
    logic [7:0] fixed_q;
    logic [3:0] ctl_sel_q;  // Select bits only; go bits read as zero
    logic       wr_q;
    logic [7:0] ptr_q, sh_q;
    volt_code_t cur_q [4];
    volt_code_t tgt_q [4];

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        case (a)
            `OFS_DVS_CONTROL:  reg_read = {ctl_sel_q[3], 1'b0, ctl_sel_q[2],
                                          1'b0, ctl_sel_q[1], 1'b0,
                                          ctl_sel_q[0], 1'b0};
            `OFS_BUCK_B_V1:    reg_read = {3'h0, bb_v1_q};
            `OFS_BUCK_B_V2:    reg_read = {3'h0, bb_v2_q};
            `OFS_BUCK_B_SL:    reg_read = {5'h00, bb_sl_q};
            `OFS_BUCK_A_V1:    reg_read = {3'h0, ba_v1_q};
            `OFS_BUCK_A_V2:    reg_read = {3'h0, ba_v2_q};
            `OFS_BUCK_A_SL:    reg_read = {5'h00, ba_sl_q};
            `OFS_LREG2_TGT:    reg_read = {3'h0, l2_tgt_q};
            `OFS_LREG4_TGT:    reg_read = {3'h0, l4_tgt_q};
            `OFS_RAMP_STATUS:  reg_read = {3'h0, BUCK_A_ON, RAMP_BUSY};
            `OFS_FIXED_SUPPLY: reg_read = fixed_q;
            default:           reg_read = 8'h00;
        endcase
    endfunction : reg_read

    // Slew code to cycles per 25 mV step; reserved 111 ramps slowest
    function automatic logic [CNT_W-1:0] step_cycles(input slew_code_t s);
        logic [CNT_W-1:0] slow;
        slow = CNT_W'(SLOW_STEP);
        case (s)
            3'h0:    step_cycles = '0;
            3'h7:    step_cycles = slow;
            default: step_cycles = slow >> (s - 3'h1);
        endcase
    endfunction : step_cycles

    function automatic logic [12:0] to_mv(input logic [12:0] base,
                                          input logic [12:0] step,
                                          input volt_code_t c);
        to_mv = base + 13'(step * c);
    endfunction : to_mv

    wire [7:0] rd_now  = reg_read(ptr_q);
    wire [7:0] rd_next = reg_read(ptr_q + 8'h01);
    wire       wr_ctl  = wr_q && ptr_q == `OFS_DVS_CONTROL;
    wire       wr_go   = wr_q && ptr_q == `OFS_LREG_GO;

    // Go decoding: either go bit starts, either select picks secondary
    wire go_a  = wr_ctl & (sh_q[`BIT_A_GO_FIRST] | sh_q[`BIT_A_GO_SECOND]);
    wire go_b  = wr_ctl & (sh_q[`BIT_B_GO_FIRST] | sh_q[`BIT_B_GO_SECOND]);
    wire sel_a = sh_q[`BIT_A_SEL_FIRST] | sh_q[`BIT_A_SEL_SECOND];
    wire sel_b = sh_q[`BIT_B_SEL_FIRST] | sh_q[`BIT_B_SEL_SECOND];
    wire [3:0] start = {wr_go & sh_q[`BIT_LREG4_GO],
                        wr_go & sh_q[`BIT_LREG2_GO], go_b, go_a};
    volt_code_t new_tgt [4];
    logic [CNT_W-1:0] new_per [4];
    assign new_tgt[0] = sel_a ? ba_v2_q : ba_v1_q;
    assign new_tgt[1] = sel_b ? bb_v2_q : bb_v1_q;
    assign new_tgt[2] = l2_tgt_q;
    assign new_tgt[3] = l4_tgt_q;
    assign new_per[0] = step_cycles(ba_sl_q);
    assign new_per[1] = step_cycles(bb_sl_q);
    assign new_per[2] = LREG_STEP;
    assign new_per[3] = LREG_STEP;

    // Host writes; only the defined field widths are stored
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ba_v1_q  <= `RST_BUCK_A_CODE;
            ba_v2_q  <= `RST_BUCK_A_CODE;
            bb_v1_q  <= `RST_BUCK_B_CODE;
            bb_v2_q  <= `RST_BUCK_B_CODE;
            ba_sl_q  <= `RST_SLEW_CODE;
            bb_sl_q  <= `RST_SLEW_CODE;
            l2_tgt_q <= `RST_LREG_CODE;
            l4_tgt_q <= `RST_LREG_CODE;
            fixed_q  <= `RST_FIXED_SUPPLY;
            ctl_sel_q <= 4'h0;
        end else if (wr_q) begin
            case (ptr_q)
                `OFS_BUCK_A_V1:    ba_v1_q  <= sh_q[4:0];
                `OFS_BUCK_A_V2:    ba_v2_q  <= sh_q[4:0];
                `OFS_BUCK_B_V1:    bb_v1_q  <= sh_q[4:0];
                `OFS_BUCK_B_V2:    bb_v2_q  <= sh_q[4:0];
                `OFS_BUCK_A_SL:    ba_sl_q  <= sh_q[2:0];
                `OFS_BUCK_B_SL:    bb_sl_q  <= sh_q[2:0];
                `OFS_LREG2_TGT:    l2_tgt_q <= sh_q[4:0];
                `OFS_LREG4_TGT:    l4_tgt_q <= sh_q[4:0];
                `OFS_FIXED_SUPPLY: fixed_q  <= sh_q;
                `OFS_DVS_CONTROL:  ctl_sel_q <= {sh_q[7], sh_q[5],
                                                 sh_q[3], sh_q[1]};
                default:           ;
            endcase
        end
    end

    // ************************************************************
    // Ramp engines: buck_a, buck_b, linear_reg_two, linear_reg_four
    // ************************************************************
    logic [CNT_W-1:0] cnt_q [4];
    logic [CNT_W-1:0] per_q [4];
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ramp
            wire restore = (g == 0) && en_evt;
            // Restart on a new go; a zero period jumps at once
            always_ff @(posedge MCLK) begin
                if (SYS_RST) begin
                    cur_q[g] <= (g < 2) ? `RST_BUCK_A_CODE : `RST_LREG_CODE;
                    tgt_q[g] <= (g < 2) ? `RST_BUCK_A_CODE : `RST_LREG_CODE;
                    cnt_q[g] <= '0;
                    per_q[g] <= '0;
                end else if (restore) begin
                    cur_q[g] <= `RST_BUCK_A_CODE;
                    tgt_q[g] <= `RST_BUCK_A_CODE;
                end else if (start[g]) begin
                    tgt_q[g] <= new_tgt[g];
                    per_q[g] <= new_per[g];
                    if (new_per[g] == '0)
                        cur_q[g] <= new_tgt[g];
                    cnt_q[g] <= new_per[g] - 1'b1;
                end else if (cur_q[g] != tgt_q[g]) begin
                    if (cnt_q[g] == '0) begin
                        // One 25 mV step, never past the target
                        cur_q[g] <= (cur_q[g] < tgt_q[g]) ? cur_q[g] + 1'b1
                                    : cur_q[g] - 1'b1;
                        cnt_q[g] <= per_q[g] - 1'b1;
                    end else begin
                        cnt_q[g] <= cnt_q[g] - 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Registered outputs
    // ************************************************************
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            BUCK_A_ON   <= 1'b0;
            BUCK_A_CODE <= `RST_BUCK_A_CODE;
            BUCK_B_CODE <= `RST_BUCK_B_CODE;
            BUCK_C_CODE <= 5'h00;
            LREG8_CODE  <= 3'h0;
            LREG2_CODE  <= `RST_LREG_CODE;
            LREG4_CODE  <= `RST_LREG_CODE;
            BUCK_A_MV   <= 13'h0000;
            BUCK_B_MV   <= 13'h0000;
            BUCK_C_MV   <= 13'h0000;
            RAMP_BUSY   <= 4'h0;
        end else begin
            BUCK_A_ON   <= ~pin_q[2];  // Pin low enables buck_a
            BUCK_A_CODE <= cur_q[0];
            BUCK_B_CODE <= cur_q[1];
            BUCK_C_CODE <= fixed_q[4:0];
            LREG8_CODE  <= fixed_q[7:5];
            LREG2_CODE  <= cur_q[2];
            LREG4_CODE  <= cur_q[3];
            BUCK_A_MV   <= to_mv(`DVS_BASE_MV, `DVS_STEP_MV,
                                 cur_q[0]);
            BUCK_B_MV   <= to_mv(`DVS_BASE_MV, `DVS_STEP_MV,
                                 cur_q[1]);
            BUCK_C_MV   <= to_mv(`BUCK_C_BASE_MV, `BUCK_C_STEP_MV,
                                 fixed_q[4:0]);
            for (int i = 0; i < 4; i++)
                RAMP_BUSY[i] <= cur_q[i] != tgt_q[i];
        end
    end

    // ************************************************************
    // I2C slave
    // ************************************************************
    serial_state_t st_q;
    logic [3:0]    bit_q;
    logic          rw_q;
    // SDA is only ever pulled low; releasing relies on the pull-up
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            rw_q <= 1'b0;
            ptr_q <= 8'h00;
            SDA_OE <= 1'b0;
            SDA_O <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            if (bus_start) begin
                st_q <= ST_ADDR;
                bit_q <= 4'h0;
                SDA_OE <= 1'b0;
            end else if (bus_stop) begin
                st_q <= ST_IDLE;
                SDA_OE <= 1'b0;
            end else if (scl_rise) begin
                case (st_q)
                    ST_ADDR, ST_REG, ST_WDATA: begin
                        sh_q <= {sh_q[6:0], sda_bit};
                        bit_q <= bit_q + 4'h1;
                    end
                    ST_RDATA: bit_q <= bit_q + 4'h1;
                    ST_MACK: if (sda_bit) st_q <= ST_IDLE;  // Master NACK
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (st_q)
                    ST_ADDR: if (bit_q == 4'h8) begin
                        if (sh_q[7:1] == DEV_ADDR) begin
                            st_q <= ST_AACK;
                            rw_q <= sh_q[0];
                            SDA_OE <= 1'b1;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                    ST_AACK: begin
                        bit_q <= 4'h0;
                        st_q <= rw_q ? ST_RDATA : ST_REG;
                        sh_q <= rd_now;
                        SDA_OE <= rw_q & ~rd_now[7];
                    end
                    ST_REG: if (bit_q == 4'h8) begin
                        st_q <= ST_REG_ACK;
                        ptr_q <= sh_q;
                        SDA_OE <= 1'b1;
                    end
                    ST_REG_ACK, ST_WACK: begin
                        st_q <= ST_WDATA;
                        bit_q <= 4'h0;
                        SDA_OE <= 1'b0;
                        if (st_q == ST_WACK) ptr_q <= ptr_q + 8'h01;
                    end
                    ST_WDATA: if (bit_q == 4'h8) begin
                        st_q <= ST_WACK;
                        wr_q <= 1'b1;
                        SDA_OE <= 1'b1;
                    end
                    ST_RDATA: if (bit_q == 4'h8) begin
                        st_q <= ST_MACK;
                        SDA_OE <= 1'b0;
                    end else begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        SDA_OE <= ~sh_q[6];
                    end
                    ST_MACK: begin
                        st_q <= ST_RDATA;
                        bit_q <= 4'h0;
                        ptr_q <= ptr_q + 8'h01;
                        sh_q <= rd_next;
                        SDA_OE <= ~rd_next[7];
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    sequence s_ldo_go;
        start[2] && new_tgt[2] != cur_q[2];
    endsequence
    sequence s_ldo_wait;
        (cur_q[2] == $past(cur_q[2])) [*8];
    endsequence

    single_step_a: assert property ($changed(cur_q[0])
        && !$past(start[0]) && !$past(en_evt) |-> cur_q[0] == $past(cur_q[0])
        + 5'h01 || $past(cur_q[0]) == cur_q[0] + 5'h01)
        else $error("buck_a code jumped by more than one step");
    // An enabling edge overrides a same-cycle go, so it is left out here
    instant_slew_a: assert property (start[0]
        && new_per[0] == '0 && !en_evt |=> cur_q[0] == $past(new_tgt[0]))
        else $error("instant slew did not jump to target");
    stop_target_a: assert property (cur_q[1] == tgt_q[1]
        && !start[1] |=> $stable(cur_q[1]))
        else $error("buck_b moved past its target");
    ldo_rate_a: assert property (s_ldo_go
        |=> per_q[2] == LREG_STEP ##0 s_ldo_wait)
        else $error("linear_reg_two not at fixed rate");
    slew_store_a: assert property (wr_q
        && ptr_q == `OFS_BUCK_A_SL |=> ba_sl_q == $past(sh_q[2:0]))
        else $error("buck_a slew code not stored");
    target_sel_a: assert property (go_a && !sel_a
        && !en_evt |=> tgt_q[0] == $past(ba_v1_q))
        else $error("primary code not chosen as target");
    enable_default_a: assert property (en_evt
        |-> ##2 BUCK_A_CODE == `RST_BUCK_A_CODE)
        else $error("buck_a did not restore default code");
    fixed_split_a: assert property (wr_q
        && ptr_q == `OFS_FIXED_SUPPLY
        |-> ##2 LREG8_CODE == $past(sh_q[7:5], 2))
        else $error("linear_reg_eight code not taken from 7:5");
    volt_store_a: assert property (wr_q
        && ptr_q == `OFS_BUCK_B_V2 |=> bb_v2_q == $past(sh_q[4:0]))
        else $error("buck_b secondary code not stored");
    // Millivolt output still holds its reset value one edge after release
    mv_map_a: assert property (!$past(SYS_RST)
        |-> BUCK_C_MV == 13'h0BB8 + 13'($past(fixed_q[4:0]) * 13'h0032))
        else $error("buck_c millivolt mapping wrong");

endmodule : dvm_buck_voltage_ramp_ctrl

// file: hdl/dvm_ramp_consts.svh
// Register offsets, field positions, reset values and timing counts
// for the voltage ramp controller. Assumes a 100 MHz device clock.
`ifndef DVM_RAMP_CONSTS_SVH
`define DVM_RAMP_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_DVS_CONTROL   8'h20
`define OFS_BUCK_B_V1     8'h23
`define OFS_BUCK_B_V2     8'h24
`define OFS_BUCK_B_SL     8'h25
`define OFS_BUCK_A_V1     8'h26
`define OFS_BUCK_A_V2     8'h27
`define OFS_BUCK_A_SL     8'h28
`define OFS_LREG2_TGT     8'h2A
`define OFS_LREG4_TGT     8'h2B
`define OFS_LREG_GO       8'h2C
`define OFS_RAMP_STATUS   8'h2D
`define OFS_FIXED_SUPPLY  8'h42

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_B_GO_SECOND   0
`define BIT_B_SEL_SECOND  1
`define BIT_A_GO_SECOND   2
`define BIT_A_SEL_SECOND  3
`define BIT_B_GO_FIRST    4
`define BIT_B_SEL_FIRST   5
`define BIT_A_GO_FIRST    6
`define BIT_A_SEL_FIRST   7
`define BIT_LREG2_GO      0
`define BIT_LREG4_GO      1
`define BIT_BUCK_A_ON     4

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_BUCK_A_CODE   5'h13
`define RST_BUCK_B_CODE   5'h13
`define RST_SLEW_CODE     3'h3
`define RST_FIXED_SUPPLY  8'h00
`define RST_LREG_CODE     5'h00

// ****************************************************************
// Voltage scales and timing
// ****************************************************************
`define DVS_BASE_MV       13'h02D5
`define DVS_STEP_MV       13'h0019
`define BUCK_C_BASE_MV    13'h0BB8
`define BUCK_C_STEP_MV    13'h0032
`define STEP_UV           25000
`define SLOWEST_RATE_UV   110
`define LREG_RATE_UV      7000
`define CLK_PERIOD_NS     10
`define SLOW_STEP_CYCLES  ((`STEP_UV * 1000 / `SLOWEST_RATE_UV) / `CLK_PERIOD_NS)
`define LREG_STEP_CYCLES  ((`STEP_UV * 1000 / `LREG_RATE_UV) / `CLK_PERIOD_NS)

`endif

// file: hdl/dvm_ramp_pkg.sv
// Types shared by the voltage ramp controller.
// Assumes the constants header is included where offsets are needed.
package dvm_ramp_pkg;

    // ************************************************************
    // Serial slave states
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_REG_ACK,
        ST_WDATA, ST_WACK, ST_RDATA, ST_MACK
    } serial_state_t;

    typedef logic [4:0] volt_code_t;
    typedef logic [2:0] slew_code_t;

endpackage : dvm_ramp_pkg

// file: verif/i2c_host_model.sv
// Host-side model of the register bus: drives SCL, pulls SDA low.
// Assumes the bench resolves SDA with a pull-up from all enables.
`timescale 1ns/10ps
module i2c_host_model (
    input  wire logic MCLK,
    input  wire logic SDA,
    output logic      SCL,
    output logic      SDA_LOW
);
    // Bus idles released, both lines high
    initial begin
        SCL = 1'b1;
        SDA_LOW = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge MCLK);
    endtask : hold
    // Data moves while SCL is low; sampled late in SCL high, off the clock edge
    task automatic bitx(input logic b, output logic r);
        SDA_LOW <= ~b;
        hold(5);
        SCL <= 1'b1;
        hold(4);
        @(negedge MCLK);
        r = SDA;
        hold(1);
        SCL <= 1'b0;
        hold(2);
    endtask : bitx
    // Eight bits MSB first, then the ninth bit given
    task automatic byte_x(input logic [7:0] d, input logic nine,
                          output logic [7:0] q, output logic r9);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], b);
            q[i] = b;
        end
        bitx(nine, r9);
    endtask : byte_x
    // START or repeated START when lvl is 0; STOP when lvl is 1
    task automatic edge_x(input logic lvl);
        SDA_LOW <= lvl;
        hold(2);
        SCL <= 1'b1;
        hold(5);
        SDA_LOW <= ~lvl;
        hold(5);
        if (lvl == 1'b0) SCL <= 1'b0;
        hold(2);
    endtask : edge_x
    // Codes are written over the bus before any go request
    task automatic wr(input logic [6:0] a, input logic [7:0] r,
                      input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic k0, k1, k2;
        edge_x(1'b0);
        byte_x({a, 1'b0}, 1'b1, q, k0);
        byte_x(r, 1'b1, q, k1);
        byte_x(d, 1'b1, q, k2);
        edge_x(1'b1);
        ok = ~(k0 | k1 | k2);
    endtask : wr
    // Pointer write, repeated START, one byte read with NACK
    task automatic rd(input logic [6:0] a, input logic [7:0] r,
                      output logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic k0, k1, k2, k3;
        edge_x(1'b0);
        byte_x({a, 1'b0}, 1'b1, q, k0);
        byte_x(r, 1'b1, q, k1);
        edge_x(1'b0);
        byte_x({a, 1'b1}, 1'b1, q, k2);
        byte_x(8'hFF, 1'b1, d, k3);
        edge_x(1'b1);
        ok = ~(k0 | k1 | k2);
    endtask : rd
endmodule : i2c_host_model

// file: verif/test_dvm_buck_voltage_ramp_ctrl.sv
// Self-checking bench for the voltage ramp controller.
// Assumes the host model above and a pull-up on SDA.
`timescale 1ns/10ps
`include "dvm_ramp_consts.svh"
module test_dvm_buck_voltage_ramp_ctrl;
    import dvm_ramp_pkg::*;
    localparam logic [6:0] DADDR = 7'h2D;  // arbitrary value
    localparam int         SLOW  = 64;     // short slowest interval
    logic scl, sda, sda_low, sda_o, sda_oe, pin, a_on, clk, rst, ok, seen;
    volt_code_t ca, cb, cc, l2, l4, mc, last, s, t;
    logic [2:0] l8;
    logic [12:0] ma, mb, mcv;
    logic [3:0] busy;
    logic [7:0] rdv, dv[7];
    logic [1:0] mon_ch;
    int error_cnt, checked, gap, exp_p, mon_on;
    logic [7:0] offs[7] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h42};
    logic [7:0] rstv[7] = '{8'h13, 8'h13, 8'h03, 8'h13, 8'h13, 8'h03, 8'h00};
    logic [7:0] msk[7] = '{8'h1F, 8'h1F, 8'h07, 8'h1F, 8'h1F, 8'h07, 8'hFF};
    // Open-drain wire with pull-up; watched channel chosen by mon_ch
    assign sda = ~(sda_low | (sda_oe & ~sda_o));
    assign mc = mon_ch == 0 ? ca : mon_ch == 1 ? cb : mon_ch == 2 ? l2 : l4;
    dvm_buck_voltage_ramp_ctrl #(.DEV_ADDR(DADDR), .SLOW_STEP(SLOW)) dut (
        .MCLK(clk), .SYS_RST(rst), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .CORE_ENABLE_PIN(pin), .BUCK_A_ON(a_on),
        .BUCK_A_CODE(ca), .BUCK_B_CODE(cb), .BUCK_C_CODE(cc),
        .LREG8_CODE(l8), .LREG2_CODE(l2), .LREG4_CODE(l4), .BUCK_A_MV(ma),
        .BUCK_B_MV(mb), .BUCK_C_MV(mcv), .RAMP_BUSY(busy));
    i2c_host_model host (.MCLK(clk), .SDA(sda), .SCL(scl), .SDA_LOW(sda_low));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic finish_test;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        host.wr(DADDR, r, d, ok);
        chk("write ack", 16'h1, ok);
    endtask : wr
    task automatic rd(input logic [7:0] r, input logic [7:0] e);
        host.rd(DADDR, r, rdv, ok);
        chk("read data", e, rdv);
    endtask : rd
    // Expected step interval; reserved slew code runs at the slowest rate
    function automatic int step_p(input int ch, input int k);
        if (ch > 1) return `LREG_STEP_CYCLES;
        if (k == 7) return SLOW;
        return SLOW >> (k - 1);
    endfunction : step_p
    // Each change of the watched code must be one step, one interval apart
    always @(negedge clk) begin
        gap++;
        if (mc !== last) begin
            if (mon_on) begin
                chk("step size", 1, mc > last ? mc - last : last - mc);
                if (seen) chk("step gap", exp_p, gap);
                seen = 1'b1;
            end
            gap = 0;
        end
        last = mc;
    end
    // Jump a buck to s at once, then ramp to t; regulators ramp from their present code, s unused
    task automatic ramp(input int ch, input int k, input volt_code_t s,
                        input volt_code_t t);
        logic [7:0] b;
        int n;
        b = ch ? `OFS_BUCK_B_V1 : `OFS_BUCK_A_V1;
        mon_ch = 2'(ch);
        exp_p = step_p(ch, k);
        // Monitor adopts the new channel before any step is judged
        repeat (2) @(posedge clk);
        if (ch < 2) begin
            wr(b + 8'h02, 8'h00);
            wr(b, 8'(s));
            wr(`OFS_DVS_CONTROL, ch ? 8'h10 : 8'h40);
            chk("instant code", s, mc);
            wr(b + 8'h02, 8'(k));
            wr(b + 8'h01, 8'(t));
            seen = 1'b0;
            mon_on = 1;
            wr(`OFS_DVS_CONTROL, ch ? 8'h03 : 8'h0C);
        end else begin
            seen = 1'b0;
            mon_on = 1;
            wr(ch == 2 ? `OFS_LREG2_TGT : `OFS_LREG4_TGT, 8'(t));
            wr(`OFS_LREG_GO, ch == 2 ? 8'h01 : 8'h02);
        end
        for (n = 0; busy[ch] !== 1'b0; n++) begin
            if (n > 8 * exp_p + 2000) begin
                error_cnt++;
                finish_test;
            end
            @(negedge clk);
        end
        repeat (3) @(negedge clk);
        mon_on = 0;
        chk("final code", t, mc);
        if (ch < 2) chk("buck mv", 725 + 25 * t, ch ? mb : ma);
    endtask : ramp
    // Main sequence
    initial begin
        {rst, pin, seen, mon_ch, error_cnt, checked, gap, mon_on} = '0;
        rst = 1'b1;
        last = '0;
        void'($urandom(32'hA622));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 7; i++) rd(offs[i], rstv[i]);
        for (int i = 0; i < 7; i++) begin
            dv[i] = 8'($urandom);
            wr(offs[i], dv[i]);
            rd(offs[i], dv[i] & msk[i]);
        end
        chk("buck_c code", dv[6][4:0], cc);
        chk("lreg8 code", dv[6][7:5], l8);
        chk("buck_c mv", 3000 + 50 * dv[6][4:0], mcv);
        wr(8'h42, 8'hFF);
        chk("buck_c top", 4550, mcv);
        rd(8'h30, 8'h00);
        rd(`OFS_LREG_GO, 8'h00);
        host.wr(DADDR ^ 7'h01, 8'h26, 8'h1F, ok);
        chk("foreign address ack", 0, ok);
        rd(8'h26, dv[3] & 8'h1F);
        for (int k = 1; k <= 7; k++) begin
            s = 5'(4 + $urandom_range(0, 23));
            t = $urandom_range(0, 1) ? s + 5'h04 : s - 5'h04;
            ramp(k % 2, k, s, t);
        end
        ramp(2, 0, 5'h00, 5'h04);
        ramp(3, 0, 5'h00, 5'h03);
        ramp(2, 0, 5'h04, 5'h01);
        wr(8'h28, 8'h00);
        wr(8'h26, 8'h05);
        wr(`OFS_DVS_CONTROL, 8'h40);
        pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("buck_a off", 0, a_on);
        pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk("buck_a default", `RST_BUCK_A_CODE, ca);
        chk("buck_a on", 1, a_on);
        finish_test;
    end
endmodule : test_dvm_buck_voltage_ramp_ctrl
